// >>> design/hbs_sequencer.sv
// Holding-brake sequencer with AXI4-Lite register slave.
// Assumes motor speed and alarm flags synchronous to mclk; runs on one clock.
//
// Overview of operation
// - Alarm or servo-off drops the brake release output, applying the brake.
// - Overtravel alone keeps the brake release output asserted.
// - Allocation 0 disables output, 1..3 pick terminal pair; latched at restart.
// - Signals sharing a terminal are ORed onto it.
// - Servo-off while stopped drops brake release in that same cycle.
// - Stopped servo-off delays power removal by 0..50 in 10 ms steps.
// - That delay applies to stopped servo-off and, if the alarm has cleared, after a zero-speed stop, not rotating stops.
// - Alarm without zero-speed stop removes motor power immediately, ignoring the delay.
// - After rotating power-off, brake applies once speed falls below level.
// - Or brake applies once wait time elapses, whichever comes first.
// - Effective speed level is clamped to the motor maximum speed.
// - Zero-speed alarm stop brings motor to rest, then stopped sequence.
// - Stop method 0 dynamic/dynamic, 1 dynamic/coast, 2 coast/coast; latched at restart.
// - Main power lost without servo-off stops by dynamic brake.
// - Zero-speed stopping is the default for applicable alarms.
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module hbs_sequencer
	import hbs_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        clkEn,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Drive status
	input  wire logic        alarmDet,
	input  wire logic        alarmZeroSpeedOk,
	input  wire logic        overtravel,
	input  wire logic        mainPowerLost,
	input  wire logic [13:0] motorSpeed,
	// Other signals wanting each terminal
	input  wire logic [2:0]  otherTermOut,
	// Outputs
	output logic [2:0]       termOut,
	output logic             motorPowerOn,
	output logic             dynamicBrakeOn,
	output logic             zeroSpeedStop
);

	// ==========================================================
	// Registers
	logic             svCmdReg;
	logic             svOffPulse;
	logic             svOnPulse;
	logic [2:0]       delayReg;
	logic [13:0]      speedLvlReg;
	logic [6:0]       waitReg;
	logic [1:0]       allocReg;
	logic [1:0]       allocActReg;
	logic [1:0]       stopMReg;
	logic [1:0]       stopMActReg;
	logic [13:0]      maxSpdReg;
	logic             zStopReg;
	logic             restartPulse;
	hbs_state_t       stateReg;
	logic             brakeRelReg;
	logic             timerStart;
	logic             timerRun;
	logic [6:0]       ticks;
	logic [13:0]      effLevel;
	logic             stopped;
	logic             brakeRelNext;
	logic             powerNext;
	logic             dbNext;
	logic             zNext;
	hbs_state_t       stateNext;
	logic             awHeld;
	logic             wHeld;
	logic [7:0]       awAddrReg;
	logic [31:0]      wDataReg;
	logic [3:0]       wStrbReg;
	logic             doWrite;
	logic             wrOk;

	// ==========================================================
	// AXI4-Lite write path
	// Address and data are captured separately, so either may arrive first.
	assign doWrite = awHeld && wHeld && !s_axi_bvalid;

	always_comb
	begin
		case (awAddrReg)
			ADDR_CTRL, ADDR_DELAY, ADDR_SPEEDLVL, ADDR_WAIT,
			ADDR_ALLOC, ADDR_STOPMETH, ADDR_MAXSPEED: wrOk = 1'b1;
			default: wrOk = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			awHeld        <= 1'b0;
			wHeld         <= 1'b0;
			awAddrReg     <= '0;
			wDataReg      <= '0;
			wStrbReg      <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else if (clkEn)
		begin
			s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld    <= 1'b1;
				awAddrReg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld    <= 1'b1;
				wDataReg <= s_axi_wdata;
				wStrbReg <= s_axi_wstrb;
			end
			if (doWrite)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrOk ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				awHeld       <= 1'b0;
				wHeld        <= 1'b0;
			end
		end
	end

	// Configuration registers; out-of-range settings are clamped, except max speed, which keeps its low 14 bits.
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			svCmdReg     <= 1'b0;
			svOffPulse   <= 1'b0;
			svOnPulse    <= 1'b0;
			restartPulse <= 1'b0;
			zStopReg     <= ZSTOP_RST;
			delayReg     <= DELAY_RST;
			speedLvlReg  <= SPEED_RST;
			waitReg      <= WAIT_RST;
			allocReg     <= ALLOC_RST;
			stopMReg     <= STOPM_RST;
			maxSpdReg    <= MAXSPD_RST;
		end
		else if (clkEn)
		begin
			svOffPulse   <= 1'b0;
			svOnPulse    <= 1'b0;
			restartPulse <= 1'b0;
			if (doWrite && wStrbReg[0])
			begin
				case (awAddrReg)
					ADDR_CTRL:
					begin
						svOnPulse    <= wDataReg[CTRL_SVON_BIT];
						svOffPulse   <= wDataReg[CTRL_SVOFF_BIT];
						restartPulse <= wDataReg[CTRL_RESTART_BIT];
						zStopReg     <= wDataReg[CTRL_ZSTOP_BIT];
					end
					ADDR_DELAY:
						delayReg <= (wDataReg[7:0] > 8'(DELAY_MAX)) ? DELAY_MAX
							: wDataReg[2:0];
					ADDR_SPEEDLVL:
						speedLvlReg <= (wDataReg[15:0] > 16'(SPEED_MAX)) ? SPEED_MAX
							: wDataReg[13:0];
					ADDR_WAIT:
						waitReg <= (wDataReg[7:0] < 8'(WAIT_MIN)) ? WAIT_MIN
							: (wDataReg[7:0] > 8'(WAIT_MAX)) ? WAIT_MAX
							: wDataReg[6:0];
					ADDR_ALLOC:
						allocReg <= wDataReg[1:0];
					ADDR_STOPMETH:
						stopMReg <= (wDataReg[1:0] == 2'h3) ? STOPM_COAST
							: wDataReg[1:0];
					ADDR_MAXSPEED:
						maxSpdReg <= wDataReg[13:0];
					default:
						svCmdReg <= svCmdReg;
				endcase
			end
			if (svOnPulse)
				svCmdReg <= 1'b1;
			if (svOffPulse)
				svCmdReg <= 1'b0;
		end
	end

	// Allocation and stop method only change on restart, which is accepted in any state, mid-motion included.
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			allocActReg <= ALLOC_RST;
			stopMActReg <= STOPM_RST;
		end
		else if (clkEn && restartPulse)
		begin
			allocActReg <= allocReg;
			stopMActReg <= stopMReg;
		end
	end

	// ==========================================================
	// AXI4-Lite read path
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (clkEn)
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				case (s_axi_araddr)
					ADDR_CTRL:     s_axi_rdata <= {28'h000_0000, zStopReg, 2'b00, svCmdReg};
					ADDR_DELAY:    s_axi_rdata <= {29'h0000_0000, delayReg};
					ADDR_SPEEDLVL: s_axi_rdata <= {18'h0_0000, speedLvlReg};
					ADDR_WAIT:     s_axi_rdata <= {25'h000_0000, waitReg};
					ADDR_ALLOC:    s_axi_rdata <= {28'h000_0000, allocActReg, allocReg};
					ADDR_STOPMETH: s_axi_rdata <= {28'h000_0000, stopMActReg, stopMReg};
					ADDR_MAXSPEED: s_axi_rdata <= {18'h0_0000, maxSpdReg};
					ADDR_STATUS:   s_axi_rdata <= {20'h0_0000, ticks, zeroSpeedStop,
						dynamicBrakeOn, motorPowerOn, brakeRelReg, stopped};
					default:
					begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Brake sequencing
	assign effLevel = (speedLvlReg > maxSpdReg) ? maxSpdReg : speedLvlReg;
	assign stopped  = (motorSpeed < effLevel);

	hbs_tick_timer u_timer (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.clkEn   (clkEn),
		.start   (timerStart),
		.run     (timerRun),
		.ticks   (ticks)
	);

	always_comb
	begin
		stateNext    = stateReg;
		brakeRelNext = brakeRelReg;
		powerNext    = motorPowerOn;
		zNext        = 1'b0;
		timerStart   = 1'b0;
		timerRun     = 1'b1;
		case (stateReg)
			ST_OFF:
			begin
				brakeRelNext = 1'b0;
				powerNext    = 1'b0;
				if (svOnPulse && !alarmDet && !mainPowerLost)
				begin
					stateNext    = ST_ON;
					brakeRelNext = 1'b1;
					powerNext    = 1'b1;
				end
			end
			ST_ON:
			begin
				// Overtravel is not a brake condition; the output stays released.
				brakeRelNext = 1'b1;
				if (alarmDet && zStopReg && alarmZeroSpeedOk && !stopped)
					stateNext = ST_ZSTOP;
				else if (alarmDet || mainPowerLost || (svOffPulse && !stopped))
				begin
					// Power goes at once; timer and speed compare start now.
					stateNext    = ST_ROTBRK;
					powerNext    = 1'b0;
					timerStart   = 1'b1;
					brakeRelNext = !stopped;
				end
				else if (svOffPulse)
				begin
					brakeRelNext = 1'b0;
					timerStart   = 1'b1;
					stateNext    = ST_DELAY;
				end
			end
			ST_DELAY:
			begin
				brakeRelNext = 1'b0;
				if (alarmDet || mainPowerLost || ticks >= 7'(delayReg))
				begin
					stateNext = ST_OFF;
					powerNext = 1'b0;
				end
			end
			ST_ZSTOP:
			begin
				// Motor held powered and commanded to zero speed until at rest.
				zNext = 1'b1;
				if (stopped || mainPowerLost)
				begin
					brakeRelNext = 1'b0;
					timerStart   = 1'b1;
					zNext        = 1'b0;
					stateNext    = mainPowerLost ? ST_OFF : ST_DELAY;
					powerNext    = !mainPowerLost;
				end
			end
			ST_ROTBRK:
			begin
				if (stopped || ticks >= waitReg)
				begin
					brakeRelNext = 1'b0;
					stateNext    = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				brakeRelNext = 1'b0;
				timerRun     = 1'b0;
				if (stopped)
					stateNext = ST_OFF;
			end
			default:
			begin
				stateNext    = ST_OFF;
				brakeRelNext = 1'b0;
				powerNext    = 1'b0;
			end
		endcase
	end

	// Dynamic brake choice; power loss without servo-off forces it.
	always_comb
	begin
		dbNext = 1'b0;
		if (!powerNext && !zNext)
		begin
			if (mainPowerLost && svCmdReg)
				dbNext = 1'b1;
			else if (stateNext == ST_ROTBRK)
				dbNext = (stopMActReg != STOPM_COAST);
			else
				dbNext = (stopMActReg == STOPM_DYN_DYN);
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stateReg       <= ST_OFF;
			brakeRelReg    <= 1'b0;
			motorPowerOn   <= 1'b0;
			dynamicBrakeOn <= 1'b1;
			zeroSpeedStop  <= 1'b0;
		end
		else if (clkEn)
		begin
			stateReg       <= stateNext;
			brakeRelReg    <= brakeRelNext;
			motorPowerOn   <= powerNext;
			dynamicBrakeOn <= dbNext;
			zeroSpeedStop  <= zNext;
		end
	end

	// ==========================================================
	// Terminal routing
	// The brake signal is ORed with whatever else owns a pair; keeping them apart
	// is up to configuration, so a shared terminal can hold the brake released.
	genvar t;
	generate
		for (t = 0; t < NUM_TERM; t++)
		begin : g_term
			always_ff @(posedge mclk or posedge sys_rst)
			begin
				if (sys_rst)
					termOut[t] <= 1'b0;
				else if (clkEn)
					termOut[t] <= otherTermOut[t]
						| (brakeRelNext && allocActReg == 2'(t + 1));
			end
		end
	endgenerate

endmodule

// >>> design/hbs_tick_timer.sv
// Counter of 10 ms ticks for the brake sequencer.
// Assumes one synchronous start pulse; clears on start, counts while run is high.
`timescale 1ns/1ps
module hbs_tick_timer
	import hbs_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       clkEn,
	// Control
	input  wire logic       start,
	input  wire logic       run,
	// Result
	output logic      [6:0] ticks
);

	logic [TICK_W-1:0] preReg;

	// A restart zeroes both stages so the first tick is a full period away.
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			preReg <= '0;
			ticks  <= '0;
		end
		else if (clkEn)
		begin
			if (start)
			begin
				preReg <= '0;
				ticks  <= '0;
			end
			else if (run)
			begin
				if (preReg == TICK_W'(TICK_CYCLES - 1))
				begin
					preReg <= '0;
					if (ticks != 7'h7F)
						ticks <= ticks + 7'h01;
				end
				else
					preReg <= preReg + TICK_W'(1);
			end
		end
	end

endmodule

// >>> inc/hbs_pkg.sv
// Constants and types for the holding-brake sequencer.
// Assumes a 100 MHz control clock; shared by the sequencer and its timer.
package hbs_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_MHZ          = 100;
	localparam int TICK_MS          = 10;
	localparam int TICK_CYCLES      = TICK_MS * 1000 * CLK_MHZ;
	localparam int TICK_W           = 20;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_DELAY     = 8'h04;
	localparam logic [7:0] ADDR_SPEEDLVL  = 8'h08;
	localparam logic [7:0] ADDR_WAIT      = 8'h0C;
	localparam logic [7:0] ADDR_ALLOC     = 8'h10;
	localparam logic [7:0] ADDR_STOPMETH  = 8'h14;
	localparam logic [7:0] ADDR_MAXSPEED  = 8'h18;
	localparam logic [7:0] ADDR_STATUS    = 8'h1C;

	// Control register bits.
	localparam int CTRL_SVON_BIT    = 0;
	localparam int CTRL_SVOFF_BIT   = 1;
	localparam int CTRL_RESTART_BIT = 2;
	localparam int CTRL_ZSTOP_BIT   = 3;

	// ==========================================================
	// Reset values and limits
	localparam logic [2:0]  DELAY_RST    = 3'h0;
	localparam logic [2:0]  DELAY_MAX    = 3'h5;
	localparam logic [13:0] SPEED_RST    = 14'h0064;
	localparam logic [13:0] SPEED_MAX    = 14'h2710;
	localparam logic [6:0]  WAIT_RST     = 7'h32;
	localparam logic [6:0]  WAIT_MIN     = 7'h0A;
	localparam logic [6:0]  WAIT_MAX     = 7'h64;
	localparam logic [1:0]  ALLOC_RST    = 2'h1;
	localparam logic [1:0]  STOPM_RST    = 2'h0;
	localparam logic [13:0] MAXSPD_RST   = 14'h1770;
	localparam logic        ZSTOP_RST    = 1'b1;
	localparam int          NUM_TERM     = 3;

	// Stop method codes.
	localparam logic [1:0] STOPM_DYN_DYN   = 2'h0;
	localparam logic [1:0] STOPM_DYN_COAST = 2'h1;
	localparam logic [1:0] STOPM_COAST    = 2'h2;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ==========================================================
	// Sequencer states
	typedef enum logic [5:0] {
		ST_OFF     = 6'b000001,
		ST_ON      = 6'b000010,
		ST_DELAY   = 6'b000100,
		ST_ROTBRK  = 6'b001000,
		ST_ZSTOP   = 6'b010000,
		ST_HOLD    = 6'b100000
	} hbs_state_t;

endpackage

// >>> verification/hbs_brake_checker.sv
// Port assertions for the holding-brake sequencer.
// Assumes a bind onto hbs_sequencer; one clock, asynchronous active-high reset.
`timescale 1ns/1ps
module hbs_brake_checker
	import hbs_pkg::*;
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        sys_rst,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	// Drive status
	input wire logic        alarmDet,
	input wire logic        alarmZeroSpeedOk,
	input wire logic        mainPowerLost,
	input wire logic [13:0] motorSpeed,
	input wire logic [2:0]  otherTermOut,
	// Outputs
	input wire logic [2:0]  termOut,
	input wire logic        motorPowerOn,
	input wire logic        dynamicBrakeOn,
	input wire logic        zeroSpeedStop
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	a_alarm_power_off: assert property (alarmDet && !alarmZeroSpeedOk |-> ##[1:3] !motorPowerOn)
		else $error("Power stayed on after an alarm.");
	a_alarm_brake_drop: assert property (alarmDet && !alarmZeroSpeedOk && motorSpeed == 14'h0000
		|-> ##[1:4] termOut == $past(otherTermOut))
		else $error("Brake still released after an alarm at rest.");
	a_other_or: assert property (1'b1 |=> (termOut & $past(otherTermOut)) == $past(otherTermOut))
		else $error("Another signal lost on its terminal.");
	a_zstop_cause: assert property ($rose(zeroSpeedStop) |-> $past(alarmDet && alarmZeroSpeedOk))
		else $error("Zero-speed stop without a matching alarm.");
	a_zstop_entry: assert property (alarmDet && alarmZeroSpeedOk && motorPowerOn
		&& motorSpeed > 14'h1770 |-> ##[1:4] zeroSpeedStop)
		else $error("Zero-speed stop not started.");
	a_powerlost_db: assert property (mainPowerLost && motorPowerOn |-> ##[1:3] dynamicBrakeOn)
		else $error("Dynamic brake not engaged on main power loss.");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
		else $error("Write response missing.");
	a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1C
		|=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("Unmapped read not refused.");

	c_zstop: cover property (zeroSpeedStop);
	c_power_off: cover property ($fell(motorPowerOn) && !alarmDet);
	c_power_lost: cover property (mainPowerLost && motorPowerOn);
endmodule

// >>> verification/hbs_brake_relay.sv
// Brake control relay and holding brake hanging on the brake terminal.
// Assumes the coil input is synchronous to mclk.
`timescale 1ns/1ps
module hbs_brake_relay #(
	parameter int RELEASE_CYC = 6,
	parameter int APPLY_CYC   = 10
)(
	// Clock
	input  wire logic mclk,
	// Relay coil
	input  wire logic coilOn,
	// Brake state
	output logic      brakeReleased
);
	int count = 0;

	// The brake lags the coil; a tester must not expect the mechanics to follow at once.
	always @(posedge mclk)
	begin
		if (coilOn === brakeReleased)
			count <= 0;
		else if (count < (coilOn ? RELEASE_CYC : APPLY_CYC))
			count <= count + 1;
		else
			brakeReleased <= coilOn;
	end

	initial brakeReleased = 1'b0;
endmodule

// >>> verification/hbs_sequencer_tb.sv
// Self-checking bench for the holding-brake sequencer.
// Assumes the package constants and the relay model on terminal pair 1.
`timescale 1ns/1ps
module hbs_sequencer_tb
	import hbs_pkg::*;
;
	// ====
	// Signals and instances
	logic        mclk, sys_rst, clkEn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, alarmDet, alarmZeroSpeedOk, overtravel;
	logic        mainPowerLost, motorPowerOn, dynamicBrakeOn, zeroSpeedStop, brakeReleased;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [13:0] motorSpeed;
	logic [2:0]  otherTermOut, termOut;
	int          mismatches, checked, cycles;

	hbs_sequencer hbs_sequencer_i (.*);
	hbs_brake_relay hbs_brake_relay_i (.mclk(mclk), .coilOn(termOut[0]),
		.brakeReleased(brakeReleased));

	// ====
	// Bus and check tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want)
		begin
			mismatches++;
			$display("Error t=%0t seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Only the bench timeout ends a wait; the master accepts any answer latency.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic sv(input logic on);
		wr(ADDR_CTRL, on ? 32'h0000_0009 : 32'h0000_000A);
		cyc(4);
	endtask

	// ====
	// Scenarios
	task automatic t_regs();
		logic [7:0]  a [8] = '{ADDR_CTRL, ADDR_DELAY, ADDR_SPEEDLVL, ADDR_WAIT, ADDR_ALLOC,
			ADDR_STOPMETH, ADDR_MAXSPEED, 8'h20};
		logic [31:0] e [8] = '{32'h0000_0008, 32'h0000_0000, 32'h0000_0064, 32'h0000_0032,
			32'h0000_0005, 32'h0000_0000, 32'h0000_1770, 32'h0000_0000};
		for (int i = 0; i < 8; i++)
		begin
			rdr(a[i]);
			chk(rd, e[i]);
			chk(rs, (i == 7) ? RESP_SLVERR : RESP_OKAY);
		end
		wr(8'h20, 32'h0000_0001);
		chk(rs, RESP_SLVERR);
		wr(ADDR_WAIT, 32'h0000_0005);
		rdr(ADDR_WAIT);
		chk(rd, 32'h0000_000A);
		wr(ADDR_ALLOC, 32'h0000_0002);
		rdr(ADDR_ALLOC);
		chk(rd, 32'h0000_0006);
		wr(ADDR_ALLOC, 32'h0000_0001);
	endtask

	task automatic t_stop();
		sv(1);
		chk(termOut, 3'b001);
		cyc(8);
		chk(brakeReleased, 1'b1);
		sv(0);
		chk(termOut, 3'b000);
		chk(motorPowerOn, 1'b0);
		chk(dynamicBrakeOn, 1'b1);
		wr(ADDR_DELAY, 32'h0000_0001);
		sv(1);
		sv(0);
		chk(termOut, 3'b000);
		cyc(200);
		chk(motorPowerOn, 1'b1);
		rdr(ADDR_STATUS);
		chk(rd, 32'h0000_0005);
		alarmDet <= 1'b1;
		cyc(4);
		chk(motorPowerOn, 1'b0);
		alarmDet <= 1'b0;
		sv(1);
		overtravel <= 1'b1;
		cyc(20);
		chk(termOut, 3'b001);
		overtravel <= 1'b0;
		motorSpeed <= 14'h0BB8;
		sv(0);
		chk(motorPowerOn, 1'b0);
		chk(termOut, 3'b001);
		motorSpeed <= 14'h0064;
		cyc(4);
		chk(termOut, 3'b001);
		clkEn <= 1'b0;
		motorSpeed <= 14'h0063;
		cyc(4);
		chk(termOut, 3'b001);
		clkEn <= 1'b1;
		cyc(4);
		chk(termOut, 3'b000);
		wr(ADDR_DELAY, 32'h0000_0000);
	endtask

	task automatic t_clamp_alarm();
		wr(ADDR_MAXSPEED, 32'h0000_01F4);
		wr(ADDR_SPEEDLVL, 32'h0000_03E8);
		sv(1);
		motorSpeed <= 14'h02BC;
		sv(0);
		chk(termOut, 3'b001);
		motorSpeed <= 14'h01F3;
		cyc(4);
		chk(termOut, 3'b000);
		wr(ADDR_MAXSPEED, 32'h0000_1770);
		wr(ADDR_SPEEDLVL, 32'h0000_0064);
		sv(1);
		motorSpeed <= 14'h0BB8;
		alarmDet <= 1'b1;
		cyc(4);
		chk(motorPowerOn, 1'b0);
		chk(termOut, 3'b001);
		motorSpeed <= 14'h0000;
		cyc(4);
		chk(termOut, 3'b000);
		alarmDet <= 1'b0;
		sv(1);
		motorSpeed <= 14'h1B58;
		alarmZeroSpeedOk <= 1'b1;
		alarmDet <= 1'b1;
		cyc(4);
		chk(zeroSpeedStop, 1'b1);
		chk(motorPowerOn, 1'b1);
		motorSpeed <= 14'h0000;
		cyc(6);
		chk(termOut, 3'b000);
		alarmDet <= 1'b0;
		alarmZeroSpeedOk <= 1'b0;
	endtask

	task automatic t_meth();
		for (int m = 0; m < 3; m++)
		begin
			wr(ADDR_STOPMETH, 32'(m));
			wr(ADDR_CTRL, 32'h0000_000C);
			rdr(ADDR_STOPMETH);
			chk(rd, 32'(m * 5));
			sv(1);
			motorSpeed <= 14'h0BB8;
			sv(0);
			chk(dynamicBrakeOn, m != 2);
			motorSpeed <= 14'h0000;
			cyc(4);
			chk(dynamicBrakeOn, m == 0);
		end
		sv(1);
		motorSpeed <= 14'h0BB8;
		mainPowerLost <= 1'b1;
		cyc(4);
		chk(dynamicBrakeOn, 1'b1);
		mainPowerLost <= 1'b0;
		motorSpeed <= 14'h0000;
		sv(0);
	endtask

	task automatic t_alloc();
		logic [2:0] want;
		for (int a = 0; a < 4; a++)
		begin
			want = (a == 0) ? 3'b000 : 3'(1 << (a - 1));
			otherTermOut <= ~want & 3'b101;
			wr(ADDR_ALLOC, 32'(a));
			wr(ADDR_CTRL, 32'h0000_000C);
			sv(1);
			chk(termOut, want | (~want & 3'b101));
			sv(0);
			chk(termOut, ~want & 3'b101);
		end
		otherTermOut <= 3'b000;
	endtask

	// ====
	// Run control
	task automatic complete_run();
		if (mismatches == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			mismatches++;
			complete_run();
		end
	end

	initial
	begin
		{mismatches, checked, cycles} = '0;
		{sys_rst, clkEn, s_axi_wstrb} = 6'b11_1111;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{alarmDet, alarmZeroSpeedOk, overtravel, mainPowerLost} = '0;
		{motorSpeed, otherTermOut} = '0;
		cyc(8);
		sys_rst <= 1'b0;
		t_regs();
		t_stop();
		t_clamp_alarm();
		t_meth();
		t_alloc();
		sys_rst <= 1'b1;
		cyc(3);
		sys_rst <= 1'b0;
		t_regs();
		complete_run();
	end
endmodule

bind hbs_sequencer hbs_brake_checker hbs_brake_checker_i (.*);
